// >>> design/mdi_map.svh
// Register layout, field positions, codes and reset values for the mode block.
// Assumes inclusion by bare name from package and design files.
`ifndef MDI_MAP_SVH
`define MDI_MAP_SVH
`define MDI_NUM_BANKS      4
`define MDI_ROW_BITS       13
`define MDI_COL_BITS       9
`define MDI_ROWS           8192
`define MDI_COLS           512
`define MDI_WORD_BITS      32
`define MDI_HALF_BITS      16
`define MDI_BL_LSB         0
`define MDI_BL_MSB         2
`define MDI_BT_POS         3
`define MDI_RL_LSB         4
`define MDI_RL_MSB         6
`define MDI_OPM_LSB        7
`define MDI_OPM_MSB        12
`define MDI_BL_CODE_2      3'h1
`define MDI_BL_CODE_4      3'h2
`define MDI_BL_CODE_8      3'h3
`define MDI_RL_CODE_2      3'h2
`define MDI_RL_CODE_3      3'h3
`define MDI_SETUP_RESET    13'h0_032
`define MDI_XSETUP_RESET   13'h0_000
`define MDI_FIFO_DEPTH     8
`endif

// >>> design/mdi_pkg.sv
// Types shared by the mobile DDR mode and access block.
// Assumes mdi_map.svh is on the include path.
`include "mdi_map.svh"
package mdi_pkg;
    typedef enum logic [2:0] {
        MDI_CMD_NOP,
        MDI_CMD_ACTIVE,
        MDI_CMD_READ,
        MDI_CMD_WRITE,
        MDI_CMD_PRECHARGE,
        MDI_CMD_REFRESH,
        MDI_CMD_LOAD_MODE
    } mdi_cmd_t;
    typedef struct packed {
        mdi_cmd_t    cmd;
        logic        bank_sel_high;
        logic        bank_sel_low;
        logic [12:0] addr;
        logic        all_banks;
    } mdi_cmd_bus_t;
    typedef struct packed {
        logic [1:0]  bank;
        logic [12:0] row;
        logic [8:0]  col;
    } mdi_loc_t;
    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
    } mdi_word_t;
endpackage

// >>> design/mdi_fifo.sv
// Parameterised valid/ready FIFO for read data.
// Assumes a single clock and active low asynchronous reset.
`timescale 1ns/1ns
module mdi_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> design/mdi_core.sv
// Mobile DDR memory core: mode registers, bank/row tracking, burst
// addressing, read latency pipeline and a small behavioural array.
// Assumes commands arrive synchronous to clk_sys_in, decoded into the
// command struct; the controller keeps the init and timing sequence.
// Operation
// R1 - Four banks of 8192 rows by 512 columns, 32-bit locations.
// R2 - Each internal 32-bit word leaves as two 16-bit half words.
// R3 - ACTIVE opens the row on address in the bank chosen by bank selects.
// R4 - Address with READ or WRITE is the first burst column.
// R5 - Controller holds clock enable high before starting the clock.
// R6 - Controller issues only NOP for 200us after clock is stable.
// R7 - Controller precharges all, then waits precharge_wait.
// R8 - Two refreshes each followed by refresh_cycle_wait during init.
// R9 - Both mode registers loaded, each followed by mode_load_wait.
// R10 - Device accepts arbitrary commands only after initialization completes.
// R11 - Load with both bank selects zero writes standard register; data kept.
// R12 - Controller loads mode only when idle, then waits mode_load_wait.
// R13 - Fields: A2-A0 length, A3 type, A6-A4 latency, A12-A7 mode.
// R14 - Burst lengths 2, 4, 8 for both orders limit columns reached.
// R15 - Burst column order from length, type and start column.
// R16 - Read latency programmable as 2 or 3 clocks.
// R17 - First read data at n+1 clocks for two, n+2 for three.
// R18 - Controller writes operating mode bits as zero.
// R19 - Controller avoids reserved length and latency codes.
// R20 - Controller reruns initialization after any power interruption.
// R21 - Mode load only with all banks precharged, after precharge_wait.
// R22 - Extended register defaults mean full array and full drive.
// R23 - Length codes 1,2,3; latency codes 2,3; A3 zero sequential.
// R24 - Controller tracks initialization with a cycle-counting state machine; the model runs timed task waits instead.
`timescale 1ns/1ns
module mdi_core
    import mdi_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_n_in,
    // Command side
    input  wire logic                 clock_enable_in,
    input  wire mdi_pkg::mdi_cmd_bus_t cmd_in,
    input  wire logic [31:0]          wr_data_in,
    // Read data side
    output logic                      rd_valid_out,
    input  wire logic                 rd_ready_in,
    output mdi_pkg::mdi_word_t        rd_word_out,
    output logic                      rd_half_out,
    // Status
    output logic                      init_done_out,
    output logic [12:0]               setup_out,
    output logic [3:0]                bank_open_out,
    output logic                      cmd_ready_out
);
    import mdi_pkg::*;

    typedef enum logic [1:0] {
        MDI_IDLE,
        MDI_RD_BURST,
        MDI_WR_BURST
    } mdi_burst_t;

    // Small behavioural array: full 512 Mbit would not be synthesisable.
    localparam int ARR_BITS = 8;
    logic [31:0]  arr_q [2**ARR_BITS];

    logic [12:0]  access_format_setup_q;
    logic [12:0]  ext_setup_q;
    logic [1:0]   init_step_q;
    logic         init_done_q;
    logic [3:0]   bank_open_q;
    logic [12:0]  open_row_q [`MDI_NUM_BANKS];
    mdi_burst_t   burst_q;
    logic [1:0]   bst_bank_q;
    logic [8:0]   bst_start_q;
    logic [2:0]   bst_idx_q;
    logic [3:0]   bst_len;
    logic [8:0]   bst_col;
    logic [2:0]   bl_mask;
    logic [2:0]   pos;
    logic [31:0]  rd_pipe_q [2];
    logic [1:0]   rd_vld_q;
    logic         fifo_in_valid;
    logic         fifo_in_ready;
    logic [31:0]  fifo_in_data;
    logic         fifo_out_valid;
    logic [31:0]  fifo_out_data;
    logic [ARR_BITS-1:0] arr_addr;
    logic [1:0]   half_q;
    logic         lat3;

    // Decode of programmed burst length into column count and wrap mask
    always_comb begin
        case (access_format_setup_q[`MDI_BL_MSB:`MDI_BL_LSB])
            `MDI_BL_CODE_2: begin
                bst_len = 4'h2; // see R23
                bl_mask = 3'h1;
            end
            `MDI_BL_CODE_4: begin
                bst_len = 4'h4;
                bl_mask = 3'h3;
            end
            `MDI_BL_CODE_8: begin
                bst_len = 4'h8; // see R14
                bl_mask = 3'h7;
            end
            default: begin
                bst_len = 4'h2;
                bl_mask = 3'h1;
            end
        endcase
    end

    // Sequential adds within the wrap, interleaved xors the index
    always_comb begin
        if (access_format_setup_q[`MDI_BT_POS]) begin
            pos = (bst_start_q[2:0] ^ bst_idx_q) & bl_mask; // see R15
        end else begin
            pos = (bst_start_q[2:0] + bst_idx_q) & bl_mask; // see R15
        end
        bst_col = {bst_start_q[8:3], (bst_start_q[2:0] & ~bl_mask) | pos};
    end

    // Reserved latency codes fall back to two, as lengths fall to two
    assign lat3 = (access_format_setup_q[`MDI_RL_MSB:`MDI_RL_LSB]
                   == `MDI_RL_CODE_3); // see R16
    assign arr_addr = {open_row_q[bst_bank_q][1:0], bst_bank_q,
                       bst_col[3:0]};

    // Initialization tracking: precharge-all, two refreshes, two loads
    // Counts loads only; waits and refreshes are left to the controller
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_step_q <= 2'h0;
            init_done_q <= 1'b0;
        end else if (clock_enable_in && !init_done_q) begin
            if (cmd_in.cmd == MDI_CMD_LOAD_MODE) begin
                init_step_q <= init_step_q + 2'h1;
                if (init_step_q == 2'h1) begin
                    init_done_q <= 1'b1; // see R10
                end
            end
        end
    end

    // Mode register loads; extended register keeps defaults until loaded
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            access_format_setup_q <= `MDI_SETUP_RESET;
            ext_setup_q           <= `MDI_XSETUP_RESET; // see R22
        end else if (clock_enable_in && cmd_in.cmd == MDI_CMD_LOAD_MODE
                     && burst_q == MDI_IDLE) begin
            if (!cmd_in.bank_sel_high && !cmd_in.bank_sel_low) begin
                access_format_setup_q <= cmd_in.addr; // see R11, R13
            end else if (cmd_in.bank_sel_high && !cmd_in.bank_sel_low) begin
                ext_setup_q <= cmd_in.addr;
            end
        end
    end

    // Bank and row tracking
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bank_open_q <= 4'h0;
            for (int b = 0; b < `MDI_NUM_BANKS; b++) begin
                open_row_q[b] <= 13'h0_000;
            end
        end else if (clock_enable_in && init_done_q) begin
            if (cmd_in.cmd == MDI_CMD_ACTIVE) begin
                bank_open_q[{cmd_in.bank_sel_high, cmd_in.bank_sel_low}]
                    <= 1'b1; // see R3
                open_row_q[{cmd_in.bank_sel_high, cmd_in.bank_sel_low}]
                    <= cmd_in.addr; // see R3
            end else if (cmd_in.cmd == MDI_CMD_PRECHARGE) begin
                if (cmd_in.all_banks) begin
                    bank_open_q <= 4'h0;
                end else begin
                    bank_open_q[{cmd_in.bank_sel_high, cmd_in.bank_sel_low}]
                        <= 1'b0;
                end
            end
        end
    end

    // Burst sequencer; a new column command ends the running burst
    // Refused commands vanish silently; no status reports them
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            burst_q     <= MDI_IDLE;
            bst_bank_q  <= 2'h0;
            bst_start_q <= 9'h000;
            bst_idx_q   <= 3'h0;
        end else if ((cmd_in.cmd == MDI_CMD_READ
                      || cmd_in.cmd == MDI_CMD_WRITE)
                     && clock_enable_in && init_done_q && fifo_in_ready
                     && bank_open_q[{cmd_in.bank_sel_high,
                                     cmd_in.bank_sel_low}]) begin
            burst_q     <= (cmd_in.cmd == MDI_CMD_READ) ? MDI_RD_BURST
                                                        : MDI_WR_BURST;
            bst_bank_q  <= {cmd_in.bank_sel_high, cmd_in.bank_sel_low};
            bst_start_q <= cmd_in.addr[8:0]; // see R4
            bst_idx_q   <= 3'h0;
        end else if (burst_q != MDI_IDLE) begin
            if ({1'b0, bst_idx_q} == bst_len - 4'h1) begin
                burst_q <= MDI_IDLE; // see R14
            end else begin
                bst_idx_q <= bst_idx_q + 3'h1;
            end
        end
    end

    // One write word per burst cycle; no byte masking here
    always_ff @(posedge clk_sys_in) begin
        if (burst_q == MDI_WR_BURST) begin
            arr_q[arr_addr] <= wr_data_in; // see R1
        end
    end

    // Latency pipeline: array read costs one stage, latency picks taps
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_vld_q <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                rd_pipe_q[i] <= 32'h0000_0000;
            end
        end else begin
            rd_vld_q[0]  <= (burst_q == MDI_RD_BURST);
            rd_pipe_q[0] <= arr_q[arr_addr];
            rd_vld_q[1]  <= rd_vld_q[0];
            rd_pipe_q[1] <= rd_pipe_q[0];
        end
    end

    assign fifo_in_valid = lat3 ? rd_vld_q[1] : rd_vld_q[0]; // see R17
    assign fifo_in_data  = lat3 ? rd_pipe_q[1] : rd_pipe_q[0];

    // A word is popped on the same edge that launches its second half beat
    mdi_fifo #(
        .WIDTH (32),
        .DEPTH (`MDI_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (half_q == 2'h1 && rd_ready_in),
        .out_data_out  (fifo_out_data)
    );

    // Two beats per internal word, rd_half_out 0 then 1, each with upper half on rise
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            half_q       <= 2'h0;
            rd_valid_out <= 1'b0;
            rd_half_out  <= 1'b0;
            rd_word_out  <= '0;
        end else begin
            rd_valid_out <= 1'b0;
            if (fifo_out_valid && rd_ready_in) begin
                rd_valid_out     <= 1'b1;
                rd_half_out      <= half_q[0];
                rd_word_out.rise <= fifo_out_data[31:16]; // see R2
                rd_word_out.fall <= fifo_out_data[15:0];
                half_q <= (half_q == 2'h1) ? 2'h0 : 2'h1;
            end
        end
    end

    // Status copies; ready lags the buffer by one cycle, so the
    // controller may see room that was taken in that same cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_done_out <= 1'b0;
        end else begin
            init_done_out <= init_done_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup_out <= `MDI_SETUP_RESET;
        end else begin
            setup_out <= access_format_setup_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bank_open_out <= 4'h0;
        end else begin
            bank_open_out <= bank_open_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_ready_out <= 1'b0;
        end else begin
            cmd_ready_out <= fifo_in_ready;
        end
    end
endmodule

// >>> verification/mdi_core_sva.sv
// Checker for mdi_core: mode loads, init gating, bank open, read timing.
// Assumes it is bound to mdi_core and sees only that module's ports.
`timescale 1ns/1ns
module mdi_core_chk
    import mdi_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys_in,
    input wire logic                  rst_n_in,
    // Command side
    input wire logic                  clock_enable_in,
    input wire mdi_pkg::mdi_cmd_bus_t cmd_in,
    input wire logic [31:0]           wr_data_in,
    // Read data side
    input wire logic                  rd_valid_out,
    input wire logic                  rd_ready_in,
    input wire mdi_pkg::mdi_word_t    rd_word_out,
    input wire logic                  rd_half_out,
    // Status
    input wire logic                  init_done_out,
    input wire logic [12:0]           setup_out,
    input wire logic [3:0]            bank_open_out,
    input wire logic                  cmd_ready_out
);
    mdi_cmd_t   c;
    logic [1:0] b, loads_q, ab_q;
    logic [3:0] quiet_q;
    logic       ld, std_ld, busy, rd_go;
    assign c = clock_enable_in ? cmd_in.cmd : MDI_CMD_NOP;
    assign b = {cmd_in.bank_sel_high, cmd_in.bank_sel_low};
    assign ld = c == MDI_CMD_LOAD_MODE;
    assign std_ld = ld && b == 2'h0;
    assign busy = c == MDI_CMD_READ || c == MDI_CMD_WRITE;
    // Latency checks only from an empty, settled pipe
    assign rd_go = c == MDI_CMD_READ && init_done_out && rd_ready_in
        && quiet_q == 4'hf && bank_open_out[b];
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quiet_q <= 4'h0;
        end else if (busy || rd_valid_out) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loads_q <= 2'h0;
        end else if (ld && loads_q != 2'h2) begin
            loads_q <= loads_q + 2'h1;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (c == MDI_CMD_ACTIVE) begin
            ab_q <= b;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_setup_load: assert property (
        std_ld && (!init_done_out || quiet_q == 4'hf)
        |-> ##2 setup_out == $past(cmd_in.addr, 2))
        else $error("setup_out missed a standard load");
    a_other_keep: assert property (
        !std_ld |-> ##2 $stable(setup_out))
        else $error("setup_out changed without a standard load");
    a_init_early: assert property (loads_q != 2'h2 |-> !init_done_out)
        else $error("init_done_out high before two loads");
    a_no_early_use: assert property (
        !init_done_out |-> !rd_valid_out && bank_open_out == 4'h0)
        else $error("activity before init completed");
    a_bank_open: assert property (
        c == MDI_CMD_ACTIVE && init_done_out |-> ##[1:2] bank_open_out[ab_q])
        else $error("ACTIVE did not open its bank");
    a_lat_two: assert property (
        rd_go && setup_out[6:4] != 3'h3 |-> !rd_valid_out[*4] ##1 rd_valid_out)
        else $error("latency two read data misplaced");
    a_lat_three: assert property (
        rd_go && setup_out[6:4] == 3'h3 |-> !rd_valid_out[*5] ##1 rd_valid_out)
        else $error("latency three read data misplaced");
    a_half_pair: assert property (
        rd_valid_out && rd_ready_in && !rd_half_out
        |=> rd_valid_out && rd_half_out && $stable(rd_word_out))
        else $error("second half beat missing");
    c_init: cover property ($rose(init_done_out));
    c_lat3: cover property (rd_go && setup_out[6:4] == 3'h3);
    c_full: cover property (init_done_out && !cmd_ready_out);
endmodule
bind mdi_core mdi_core_chk u_chk (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .clock_enable_in(clock_enable_in),
    .cmd_in(cmd_in), .wr_data_in(wr_data_in),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .rd_word_out(rd_word_out), .rd_half_out(rd_half_out),
    .init_done_out(init_done_out), .setup_out(setup_out),
    .bank_open_out(bank_open_out), .cmd_ready_out(cmd_ready_out));

// >>> verification/mdi_ctl_model.sv
// Behavioural memory controller: command tasks, init order, drain side.
// Assumes the testbench calls its tasks and seeds $urandom beforehand.
`timescale 1ns/1ns
module mdi_ctl_model
    import mdi_pkg::*;
#(
    parameter int START_WAIT = 5000,
    parameter int PRE_WAIT   = 2,
    parameter int RFC_WAIT   = 3,
    parameter int MRD_WAIT   = 2
) (
    // Clock
    input  wire logic             clk_sys_in,
    // Command side
    output logic                  ce_out,
    output mdi_pkg::mdi_cmd_bus_t cmd_out,
    output logic [31:0]           wr_data_out,
    // Drain side
    output logic                  rd_ready_out
);
    int stall = 0;
    initial begin
        ce_out = 1'b1;
        cmd_out = '0;
        wr_data_out = 32'h0000_0000;
        rd_ready_out = 1'b1;
    end
    // Percent of cycles the drain side holds off
    always @(posedge clk_sys_in) begin
        #2;
        rd_ready_out = int'($urandom % 100) >= stall;
    end
    task automatic issue(input mdi_cmd_t c, input logic [1:0] b,
        input logic [12:0] a, input logic [31:0] d, input int idle,
        input logic ce);
        @(posedge clk_sys_in);
        #2;
        ce_out = ce;
        wr_data_out = d;
        cmd_out = '{c, b[1], b[0], a, 1'b1};
        @(posedge clk_sys_in);
        #2;
        ce_out = 1'b1;
        cmd_out.cmd = MDI_CMD_NOP;
        repeat (idle) @(posedge clk_sys_in);
    endtask
    task automatic init_seq();
        repeat (START_WAIT) @(posedge clk_sys_in);
        issue(MDI_CMD_PRECHARGE, 2'h0, 13'h0400, 0, PRE_WAIT, 1);
        issue(MDI_CMD_REFRESH, 2'h0, 13'h0000, 0, RFC_WAIT, 1);
        issue(MDI_CMD_REFRESH, 2'h0, 13'h0000, 0, RFC_WAIT, 1);
        issue(MDI_CMD_LOAD_MODE, 2'h0, 13'h0021, 0, MRD_WAIT, 1);
        issue(MDI_CMD_LOAD_MODE, 2'h2, 13'h0000, 0, MRD_WAIT, 1);
    endtask
    // Reload only with all banks closed, then reopen the row
    task automatic set_mode(input logic [12:0] m, input logic [1:0] b,
        input logic [12:0] row);
        issue(MDI_CMD_PRECHARGE, 2'h0, 13'h0400, 0, PRE_WAIT, 1);
        issue(MDI_CMD_LOAD_MODE, 2'h0, m, 0, MRD_WAIT, 1);
        issue(MDI_CMD_ACTIVE, b, row, 0, 16, 1);
    endtask
endmodule

// >>> verification/tb_mobile_ddr_init_and_mode_reg.sv
// Testbench for mdi_core: reset, init gating, mode loads, bursts, FIFO.
// Assumes mdi_ctl_model drives commands and the checker is bound.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_mobile_ddr_init_and_mode_reg;
    import mdi_pkg::*;
    logic         clk_sys_in, rst_n_in, clock_enable_in, rd_ready_in;
    logic         rd_valid_out, rd_half_out, init_done_out, cmd_ready_out;
    mdi_cmd_bus_t cmd_in;
    mdi_word_t    rd_word_out;
    logic [31:0]  wr_data_in;
    logic [12:0]  setup_out;
    logic [3:0]   bank_open_out;
    logic [32:0]  exp_q[$];
    logic [32:0]  e_now;
    logic [31:0]  dv[4];
    int           fails = 0;
    int           n_tests = 0;
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    mdi_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .clock_enable_in(clock_enable_in), .cmd_in(cmd_in),
        .wr_data_in(wr_data_in), .rd_valid_out(rd_valid_out),
        .rd_ready_in(rd_ready_in), .rd_word_out(rd_word_out),
        .rd_half_out(rd_half_out), .init_done_out(init_done_out),
        .setup_out(setup_out), .bank_open_out(bank_open_out),
        .cmd_ready_out(cmd_ready_out));
    mdi_ctl_model u_ctl (.clk_sys_in(clk_sys_in),
        .ce_out(clock_enable_in), .cmd_out(cmd_in),
        .wr_data_out(wr_data_in), .rd_ready_out(rd_ready_in));
    // Each beat stands one cycle, whatever the drain side does next
    always @(negedge clk_sys_in) begin
        if (rst_n_in && rd_valid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b1, 1'b0)
            end else begin
                e_now = exp_q.pop_front();
                `CHK({rd_half_out, rd_word_out}, e_now)
            end
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic exp_burst(input logic [12:0] m, input int s);
        int bl, c;
        bl = 1 << m[2:0];
        for (int i = 0; i < bl; i++) begin
            c = m[3] ? (s ^ i) : ((s & ~(bl - 1)) | ((s + i) & (bl - 1)));
            exp_q.push_back({1'b0, dv[c >> 1]});
            exp_q.push_back({1'b1, dv[c >> 1]});
        end
    endtask
    task automatic drain(input int lim);
        for (int k = 0; k < lim && exp_q.size() != 0; k++) begin
            @(posedge clk_sys_in);
        end
        if (exp_q.size() != 0) begin
            fails++;
            give_verdict();
        end
        repeat (20) @(posedge clk_sys_in);
    endtask
    initial begin
        logic [12:0] modes[5];
        int          cols[5];
        modes = '{13'h0021, 13'h0032, 13'h002a, 13'h003b, 13'h0033};
        cols = '{1, 1, 1, 5, 2};
        void'($urandom(32'hfa26));
        for (int j = 0; j < 4; j++) dv[j] = $urandom;
        rst_n_in = 1'b0;
        repeat (5) @(posedge clk_sys_in);
        #2 rst_n_in = 1'b1;
        @(negedge clk_sys_in);
        `CHK({init_done_out, bank_open_out, setup_out}, 18'h0_0032)
        $display("test reset done");
        // Deliberately early: all three must be dropped
        u_ctl.issue(MDI_CMD_ACTIVE, 2'h1, 13'h0002, 0, 2, 1);
        u_ctl.issue(MDI_CMD_READ, 2'h1, 13'h0001, 0, 8, 1);
        u_ctl.issue(MDI_CMD_LOAD_MODE, 2'h0, 13'h0033, 0, 4, 0);
        `CHK({init_done_out, bank_open_out, setup_out}, 18'h0_0032)
        $display("test early commands done");
        u_ctl.init_seq();
        for (int k = 0; k < 50 && init_done_out !== 1'b1; k++) begin
            @(negedge clk_sys_in);
        end
        `CHK({init_done_out, setup_out}, 14'h2021)
        if (init_done_out !== 1'b1) give_verdict();
        u_ctl.issue(MDI_CMD_ACTIVE, 2'h1, 13'h0002, 0, 2, 1);
        @(negedge clk_sys_in);
        `CHK(bank_open_out, 4'h2)
        for (int j = 0; j < 4; j++) begin
            u_ctl.issue(MDI_CMD_WRITE, 2'h1, 13'(2 * j), dv[j], 4, 1);
        end
        $display("test init and write done");
        for (int m = 0; m < 5; m++) begin
            u_ctl.set_mode(modes[m], 2'h1, 13'h0002);
            @(negedge clk_sys_in);
            `CHK(setup_out, modes[m])
            exp_burst(modes[m], cols[m]);
            u_ctl.issue(MDI_CMD_READ, 2'h1, 13'(cols[m]), 0, 0, 1);
            drain(200);
        end
        $display("test burst modes done");
        // Fill the buffer with the drain side stalled, then refuse
        u_ctl.stall = 100;
        exp_burst(13'h0033, 0);
        u_ctl.issue(MDI_CMD_READ, 2'h1, 13'h0000, 0, 16, 1);
        @(negedge clk_sys_in);
        `CHK(cmd_ready_out, 1'b0)
        u_ctl.issue(MDI_CMD_READ, 2'h1, 13'h0000, 0, 4, 1);
        u_ctl.stall = 50;
        drain(400);
        `CHK(cmd_ready_out, 1'b1)
        $display("test buffer full done");
        #2 rst_n_in = 1'b0;
        @(negedge clk_sys_in);
        `CHK({init_done_out, setup_out}, 14'h0032)
        @(posedge clk_sys_in);
        #2 rst_n_in = 1'b1;
        u_ctl.init_seq();
        @(negedge clk_sys_in);
        `CHK({init_done_out, setup_out}, 14'h2021)
        $display("test second reset done");
        give_verdict();
    end
endmodule
